// >>> hbp_pkg.sv
// Shared constants, types and helpers of the host bus port
package hbp_pkg;
  // ***************************************************
  // Widths and control line positions
  // ***************************************************
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int CTL_W = 6;
  localparam int C_FRAME = 0;
  localparam int C_IRDY = 1;
  localparam int C_TRDY = 2;
  localparam int C_STOP = 3;
  localparam int C_DEVSEL = 4;
  localparam int C_PERR = 5;
  // ***************************************************
  // Bus commands
  // ***************************************************
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // ***************************************************
  // Decode windows, timing and storage
  // ***************************************************
  localparam logic [31:0] DEV_IO_BASE = 32'h0000_1000;
  localparam logic [31:0] DEV_MEM_BASE = 32'h8000_0000;
  localparam logic [31:0] WIN_MASK = 32'hFFFF_FFC0;
  localparam logic [2:0] ABORT_CYC = 3'h5;
  localparam int MEM_WORDS = 16;
  typedef enum logic [1:0] {ST_OK, ST_STOP, ST_ABORT} hbp_stat_t;
  // Even parity bit over data and command lanes
  function automatic logic hbp_par(input logic [31:0] ad, input logic [3:0] cbe);
    hbp_par = ^{ad, cbe};
  endfunction
  // Odd command codes move data toward the target
  function automatic logic hbp_is_wr(input logic [3:0] cmd);
    hbp_is_wr = cmd[0];
  endfunction
  function automatic logic hbp_is_mem(input logic [3:0] cmd);
    hbp_is_mem = (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR);
  endfunction
endpackage

// >>> hbp_bus_if.sv
// Shared bus wiring of the host bus port with one modport per party
interface hbp_bus_if;
  import hbp_pkg::*;
  logic [31:0] d_ad_o, h_ad_o, ad;
  logic d_ad_oe, h_ad_oe;
  logic [3:0] d_cbe_o, h_cbe_o, cbe;
  logic d_cbe_oe, h_cbe_oe;
  logic d_par_o, h_par_o, d_par_oe, h_par_oe, par;
  logic [CTL_W-1:0] d_ctl_o, d_ctl_oe, h_ctl_o, h_ctl_oe, ctl;
  logic req_n, gnt_n, idsel;
  logic d_inta_o, d_inta_oe, inta_n, d_serr_o, d_serr_oe, serr_n;
  // ***************************************************
  // Wire resolution, undriven lines float high
  // ***************************************************
  assign ad = d_ad_oe ? d_ad_o : (h_ad_oe ? h_ad_o : '1);
  assign cbe = d_cbe_oe ? d_cbe_o : (h_cbe_oe ? h_cbe_o : '1);
  assign par = d_par_oe ? d_par_o : (h_par_oe ? h_par_o : 1'b1);
  // Wired-AND so a clash shows as a low, like the real wire
  assign ctl = (d_ctl_o | ~d_ctl_oe) & (h_ctl_o | ~h_ctl_oe);
  assign inta_n = ~d_inta_oe | d_inta_o;
  assign serr_n = ~d_serr_oe | d_serr_o;
  modport dev (
    output d_ad_o, d_ad_oe, d_cbe_o, d_cbe_oe, d_par_o, d_par_oe, d_ctl_o, d_ctl_oe,
    output req_n, d_inta_o, d_inta_oe, d_serr_o, d_serr_oe,
    input ad, cbe, par, ctl, gnt_n, idsel
  );
  modport host (
    output h_ad_o, h_ad_oe, h_cbe_o, h_cbe_oe, h_par_o, h_par_oe, h_ctl_o, h_ctl_oe,
    output gnt_n, idsel,
    input ad, cbe, par, ctl, req_n, inta_n, serr_n
  );
endinterface

// >>> hbp_dev_end.sv
// Device end of the host bus port: target, master, parity and error signalling
// Summary of operation
// [R1] One address phase, then data phases
// [R2] I/O byte address; memory, config dword address
// [R3] Little-endian lanes, byte zero on low bits
// [R4] Command in address phase, then byte enables
// [R5] Byte enables valid all data phase
// [R6] Even parity over data, enables, parity
// [R7] Address parity valid one clock later
// [R8] Data parity one clock after ready
// [R9] Parity held until one clock after completion
// [R10] Master drives write parity, target read parity
// [R11] Frame starts, spans, drops in final phase
// [R12] Data done when both readies low
// [R13] Target stops; master ends on stop
// [R14] Config access only with device select input
// [R15] Target claims; master watches for claim
// [R16] Request bus, start only after grant
// [R17] Open-drain low-level interrupt while pending
// [R18] Address parity error pulses system error once
// [R19] Parity error two clocks after detection; code drives it one clock after detection, two after the data phase
// [R20] No parity error before claim and data
// [R21] Drive high one clock before release
// [R22] Reset releases lines and clears sequencers
// [R23] Check received parity one clock later
module hbp_dev_end
  import hbp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  hbp_bus_if.dev bus,
  input wire logic i_irq,
  input wire logic i_mst_req,
  input wire logic [3:0] i_mst_cmd,
  input wire logic [31:0] i_mst_addr,
  input wire logic [31:0] i_mst_wdata,
  input wire logic [3:0] i_mst_be,
  output logic o_mst_busy,
  output logic o_mst_done,
  output logic [31:0] o_mst_rdata,
  output hbp_stat_t o_mst_stat,
  output logic o_tgt_rd,
  output logic o_tgt_wr,
  output logic [3:0] o_tgt_cmd,
  output logic [31:0] o_tgt_addr,
  output logic [31:0] o_tgt_wdata,
  output logic [3:0] o_tgt_be,
  input wire logic [31:0] i_tgt_rdata,
  output logic o_serr_evt,
  output logic o_perr_evt
);
  typedef enum logic [2:0] {S_IDLE, S_T_CLAIM, S_T_DATA, S_T_END, S_M_ADDR, S_M_DATA,
    S_M_END} hbp_dst_t;
  hbp_dst_t state_ff;
  logic frame_q_ff, pend_ff, dsel_seen_ff, irq_ff;
  logic [3:0] cmd_ff, be_ff, cbe_o_ff;
  logic [31:0] addr_ff, wdata_ff, ad_o_ff;
  logic [4:0] ctl_o_ff, ctl_oe_ff;
  logic ad_oe_ff, cbe_oe_ff, par_o_ff, par_oe_ff;
  logic [2:0] cnt_ff;
  logic achk_ff, apar_ff, dchk_ff, dpar_ff, serr_ff;
  logic perr_o_ff, perr_oe_ff, perr_hold_ff;
  logic frame_n, irdy_n, trdy_n, stop_n, devsel_n;
  logic addr_start, tgt_hit, mst_go, perr_det;
  // ***************************************************
  // Bus observation and address decode
  // ***************************************************
  assign frame_n = bus.ctl[C_FRAME];
  assign irdy_n = bus.ctl[C_IRDY];
  assign trdy_n = bus.ctl[C_TRDY];
  assign stop_n = bus.ctl[C_STOP];
  assign devsel_n = bus.ctl[C_DEVSEL];
  // [R1] address phase start
  assign addr_start = (state_ff == S_IDLE) && !frame_n && frame_q_ff;
  // [R14] config needs select input
  // [R2] io compares bytes, others dwords
  always_comb begin
    unique case (bus.cbe)
      CMD_CFG_RD, CMD_CFG_WR: tgt_hit = bus.idsel && (bus.ad[1:0] == 2'b00);
      CMD_IO_RD, CMD_IO_WR: tgt_hit = (bus.ad & WIN_MASK) == DEV_IO_BASE;
      CMD_MEM_RD, CMD_MEM_WR: tgt_hit = (bus.ad[31:2] & WIN_MASK[31:2]) == DEV_MEM_BASE[31:2];
      default: tgt_hit = 1'b0;
    endcase
  end
  // [R16] start only with grant on idle bus
  assign mst_go = (state_ff == S_IDLE) && pend_ff && !bus.gnt_n && frame_n && irdy_n;
  // ***************************************************
  // Pin drivers
  // ***************************************************
  assign bus.d_ctl_o = {perr_o_ff, ctl_o_ff};
  assign bus.d_ctl_oe = {perr_oe_ff, ctl_oe_ff};
  assign bus.d_ad_o = ad_o_ff;
  assign bus.d_ad_oe = ad_oe_ff;
  assign bus.d_cbe_o = cbe_o_ff;
  assign bus.d_cbe_oe = cbe_oe_ff;
  assign bus.d_par_o = par_o_ff;
  assign bus.d_par_oe = par_oe_ff;
  assign bus.req_n = ~pend_ff;
  // [R17] open drain, low while pending
  assign bus.d_inta_o = 1'b0;
  assign bus.d_inta_oe = irq_ff;
  // [R18] one clock low per error
  assign bus.d_serr_o = 1'b0;
  assign bus.d_serr_oe = serr_ff;
  assign o_serr_evt = serr_ff;
  assign o_mst_busy = pend_ff;
  // Interrupt level, registered to keep the pin glitch free
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= i_irq;
    end
  end
  // Pending master request, held until the bus sequence ends
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_ff <= 1'b0;
      cmd_ff <= 4'h0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      be_ff <= 4'h0;
    end else if (!pend_ff && i_mst_req) begin
      pend_ff <= 1'b1;
      cmd_ff <= i_mst_cmd;
      addr_ff <= i_mst_addr;
      wdata_ff <= i_mst_wdata;
      be_ff <= i_mst_be;
    end else if (state_ff == S_M_END) begin
      pend_ff <= 1'b0;
    end
  end
  // ***************************************************
  // Main sequencer
  // ***************************************************
  // [R22] reset floats every line but the request, which is driven high
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= S_IDLE;
      frame_q_ff <= 1'b1;
      ctl_o_ff <= '1;
      ctl_oe_ff <= '0;
      ad_o_ff <= 32'h0000_0000;
      ad_oe_ff <= 1'b0;
      cbe_o_ff <= 4'h0;
      cbe_oe_ff <= 1'b0;
      cnt_ff <= 3'h0;
      dsel_seen_ff <= 1'b0;
      o_tgt_rd <= 1'b0;
      o_tgt_wr <= 1'b0;
      o_tgt_cmd <= 4'h0;
      o_tgt_addr <= 32'h0000_0000;
      o_tgt_wdata <= 32'h0000_0000;
      o_tgt_be <= 4'h0;
      o_mst_done <= 1'b0;
      o_mst_rdata <= 32'h0000_0000;
      o_mst_stat <= ST_OK;
    end else begin
      frame_q_ff <= frame_n;
      o_tgt_rd <= 1'b0;
      o_tgt_wr <= 1'b0;
      o_mst_done <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          if (addr_start && tgt_hit) begin
            // [R15] claim, own ready and stop
            ctl_o_ff[C_DEVSEL] <= 1'b0;
            ctl_oe_ff[C_DEVSEL] <= 1'b1;
            ctl_oe_ff[C_TRDY] <= 1'b1;
            ctl_oe_ff[C_STOP] <= 1'b1;
            o_tgt_cmd <= bus.cbe;
            o_tgt_addr <= (bus.cbe[3:1] == CMD_IO_RD[3:1]) ? bus.ad : {bus.ad[31:2], 2'b00};
            o_tgt_rd <= !hbp_is_wr(bus.cbe);
            state_ff <= S_T_CLAIM;
          end else if (mst_go) begin
            // [R11] frame low with address
            // [R4] command on enables
            ctl_o_ff[C_FRAME] <= 1'b0;
            ctl_oe_ff[C_FRAME] <= 1'b1;
            ctl_oe_ff[C_IRDY] <= 1'b1;
            ad_o_ff <= addr_ff;
            ad_oe_ff <= 1'b1;
            cbe_o_ff <= cmd_ff;
            cbe_oe_ff <= 1'b1;
            state_ff <= S_M_ADDR;
          end
        end
        S_T_CLAIM: begin
          // [R13] single phase, disconnect with data
          ctl_o_ff[C_TRDY] <= 1'b0;
          ctl_o_ff[C_STOP] <= 1'b0;
          ad_o_ff <= i_tgt_rdata;
          ad_oe_ff <= !hbp_is_wr(o_tgt_cmd);
          state_ff <= S_T_DATA;
        end
        S_T_DATA: begin
          // [R12] our ready low, wait initiator
          if (!irdy_n) begin
            // [R3] byte enable n covers bits 8n+7..8n
            // [R5] enables taken with the data
            o_tgt_wr <= hbp_is_wr(o_tgt_cmd);
            o_tgt_wdata <= bus.ad;
            o_tgt_be <= bus.cbe;
            // [R21] drive high before release
            ctl_o_ff <= '1;
            ad_oe_ff <= 1'b0;
            state_ff <= S_T_END;
          end
        end
        S_T_END: begin
          ctl_oe_ff <= '0;
          state_ff <= S_IDLE;
        end
        S_M_ADDR: begin
          // [R11] single data phase, frame ends now
          ctl_o_ff[C_FRAME] <= 1'b1;
          ctl_o_ff[C_IRDY] <= 1'b0;
          cbe_o_ff <= be_ff;
          ad_o_ff <= wdata_ff;
          ad_oe_ff <= hbp_is_wr(cmd_ff);
          cnt_ff <= 3'h0;
          dsel_seen_ff <= 1'b0;
          state_ff <= S_M_DATA;
        end
        S_M_DATA: begin
          cnt_ff <= cnt_ff + 3'h1;
          // [R15] remember any claim
          if (!devsel_n) begin
            dsel_seen_ff <= 1'b1;
          end
          // [R13] stop or abort ends the cycle
          if (!trdy_n || !stop_n || (!dsel_seen_ff && devsel_n && cnt_ff == ABORT_CYC)) begin
            o_mst_done <= 1'b1;
            o_mst_rdata <= bus.ad;
            o_mst_stat <= !trdy_n ? ST_OK : (!stop_n ? ST_STOP : ST_ABORT);
            ctl_o_ff[C_IRDY] <= 1'b1;
            ctl_oe_ff[C_FRAME] <= 1'b0;
            ad_oe_ff <= 1'b0;
            cbe_oe_ff <= 1'b0;
            state_ff <= S_M_END;
          end
        end
        S_M_END: begin
          ctl_oe_ff <= '0;
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
  // ***************************************************
  // Parity generation
  // ***************************************************
  // [R6] even parity of what is on the lanes
  // [R10] driven only behind our own data
  // [R7] [R8] [R9] one clock behind the data
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_o_ff <= 1'b0;
      par_oe_ff <= 1'b0;
    end else begin
      par_o_ff <= hbp_par(ad_o_ff, bus.cbe);
      par_oe_ff <= ad_oe_ff;
    end
  end
  // ***************************************************
  // Parity checking and error reporting
  // ***************************************************
  // [R23] capture, compare next clock
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      achk_ff <= 1'b0;
      apar_ff <= 1'b0;
      dchk_ff <= 1'b0;
      dpar_ff <= 1'b0;
      serr_ff <= 1'b0;
    end else begin
      achk_ff <= addr_start;
      apar_ff <= hbp_par(bus.ad, bus.cbe);
      // [R20] only claimed, completed phases
      dchk_ff <= ((state_ff == S_T_DATA) && !irdy_n && hbp_is_wr(o_tgt_cmd))
        || ((state_ff == S_M_DATA) && !trdy_n && !devsel_n && !hbp_is_wr(cmd_ff));
      dpar_ff <= hbp_par(bus.ad, bus.cbe);
      // [R18] single clock pulse
      serr_ff <= achk_ff && (bus.par != apar_ff);
    end
  end
  assign perr_det = dchk_ff && (bus.par != dpar_ff);
  // [R19] low from second clock after data
  // [R21] high one clock, then float
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      perr_o_ff <= 1'b1;
      perr_oe_ff <= 1'b0;
      perr_hold_ff <= 1'b0;
      o_perr_evt <= 1'b0;
    end else begin
      o_perr_evt <= perr_det;
      if (perr_det) begin
        perr_o_ff <= 1'b0;
        perr_oe_ff <= 1'b1;
        perr_hold_ff <= 1'b0;
      end else if (!perr_o_ff) begin
        perr_o_ff <= 1'b1;
        perr_hold_ff <= 1'b1;
      end else if (perr_hold_ff) begin
        perr_oe_ff <= 1'b0;
        perr_hold_ff <= 1'b0;
      end
    end
  end
endmodule

// >>> hbp_host_end.sv
// Host end of the host bus port: arbiter, host initiator and memory target
module hbp_host_end
  import hbp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  hbp_bus_if.host bus,
  input wire logic i_h_req,
  input wire logic [3:0] i_h_cmd,
  input wire logic [31:0] i_h_addr,
  input wire logic [31:0] i_h_wdata,
  input wire logic [3:0] i_h_be,
  output logic o_h_busy,
  output logic o_h_done,
  output logic [31:0] o_h_rdata,
  output hbp_stat_t o_h_stat,
  output logic o_h_perr_evt,
  output logic o_h_irq,
  output logic o_h_serr
);
  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_END} hbp_hst_t;
  typedef enum logic [1:0] {G_IDLE, G_CLAIM, G_DATA, G_END} hbp_tst_t;
  hbp_hst_t m_ff;
  hbp_tst_t t_ff;
  logic [31:0] mem [MEM_WORDS];
  logic pend_ff, gnt_ff, idsel_ff, frame_q_ff, seen_ff, par_o_ff, par_oe_ff;
  logic [3:0] cmd_ff, be_ff, cbe_o_ff, t_idx_ff;
  logic [31:0] addr_ff, wdata_ff, m_ad_ff, t_ad_ff;
  logic m_ad_oe_ff, t_ad_oe_ff, cbe_oe_ff, t_wr_ff;
  logic [1:0] m_o_ff, m_oe_ff;
  logic [2:0] t_o_ff, t_oe_ff, cnt_ff;
  logic dchk_ff, dpar_ff, perr_o_ff, perr_oe_ff, perr_hold_ff, perr_det;
  logic [31:0] ad_o;
  // ***************************************************
  // Pin drivers
  // ***************************************************
  assign ad_o = m_ad_oe_ff ? m_ad_ff : t_ad_ff;
  assign bus.h_ad_o = ad_o;
  assign bus.h_ad_oe = m_ad_oe_ff | t_ad_oe_ff;
  assign bus.h_cbe_o = cbe_o_ff;
  assign bus.h_cbe_oe = cbe_oe_ff;
  assign bus.h_par_o = par_o_ff;
  assign bus.h_par_oe = par_oe_ff;
  assign bus.h_ctl_o = {perr_o_ff, t_o_ff, m_o_ff};
  assign bus.h_ctl_oe = {perr_oe_ff, t_oe_ff, m_oe_ff};
  assign bus.gnt_n = ~gnt_ff;
  assign bus.idsel = idsel_ff;
  assign o_h_busy = pend_ff;
  assign o_h_irq = ~bus.inta_n;
  assign o_h_serr = ~bus.serr_n;
  // Arbiter: host wins ties, a grant holds while the request stays
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      gnt_ff <= 1'b0;
    end else begin
      gnt_ff <= !bus.req_n && (gnt_ff || (m_ff == H_IDLE && !pend_ff));
    end
  end
  // Host request capture
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_ff <= 1'b0;
      cmd_ff <= 4'h0;
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      be_ff <= 4'h0;
    end else if (!pend_ff && i_h_req) begin
      pend_ff <= 1'b1;
      cmd_ff <= i_h_cmd;
      addr_ff <= i_h_addr;
      wdata_ff <= i_h_wdata;
      be_ff <= i_h_be;
    end else if (m_ff == H_END) begin
      pend_ff <= 1'b0;
    end
  end
  // ***************************************************
  // Host initiator, one data phase per request
  // ***************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      m_ff <= H_IDLE;
      m_o_ff <= '1;
      m_oe_ff <= '0;
      m_ad_ff <= 32'h0000_0000;
      m_ad_oe_ff <= 1'b0;
      cbe_o_ff <= 4'h0;
      cbe_oe_ff <= 1'b0;
      idsel_ff <= 1'b0;
      cnt_ff <= 3'h0;
      seen_ff <= 1'b0;
      o_h_done <= 1'b0;
      o_h_rdata <= 32'h0000_0000;
      o_h_stat <= ST_OK;
    end else begin
      o_h_done <= 1'b0;
      unique case (m_ff)
        H_IDLE: begin
          if (pend_ff && !gnt_ff && bus.ctl[C_FRAME] && bus.ctl[C_IRDY] && t_ff == G_IDLE) begin
            m_o_ff <= 2'h2;
            m_oe_ff <= '1;
            m_ad_ff <= addr_ff;
            m_ad_oe_ff <= 1'b1;
            cbe_o_ff <= cmd_ff;
            cbe_oe_ff <= 1'b1;
            idsel_ff <= (cmd_ff[3:1] == CMD_CFG_RD[3:1]);
            m_ff <= H_ADDR;
          end
        end
        H_ADDR: begin
          m_o_ff <= 2'h1;
          m_ad_ff <= wdata_ff;
          m_ad_oe_ff <= hbp_is_wr(cmd_ff);
          cbe_o_ff <= be_ff;
          idsel_ff <= 1'b0;
          cnt_ff <= 3'h0;
          seen_ff <= 1'b0;
          m_ff <= H_DATA;
        end
        H_DATA: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (!bus.ctl[C_DEVSEL]) begin
            seen_ff <= 1'b1;
          end
          if (!bus.ctl[C_TRDY] || !bus.ctl[C_STOP]
              || (!seen_ff && bus.ctl[C_DEVSEL] && cnt_ff == ABORT_CYC)) begin
            o_h_done <= 1'b1;
            o_h_rdata <= bus.ad;
            o_h_stat <= !bus.ctl[C_TRDY] ? ST_OK : (!bus.ctl[C_STOP] ? ST_STOP : ST_ABORT);
            m_o_ff <= '1;
            m_oe_ff <= 2'h2;
            m_ad_oe_ff <= 1'b0;
            cbe_oe_ff <= 1'b0;
            m_ff <= H_END;
          end
        end
        H_END: begin
          m_oe_ff <= '0;
          m_ff <= H_IDLE;
        end
      endcase
    end
  end
  // ***************************************************
  // Memory target serving the device's own transfers
  // ***************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      t_ff <= G_IDLE;
      frame_q_ff <= 1'b1;
      t_o_ff <= '1;
      t_oe_ff <= '0;
      t_ad_ff <= 32'h0000_0000;
      t_ad_oe_ff <= 1'b0;
      t_idx_ff <= 4'h0;
      t_wr_ff <= 1'b0;
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      frame_q_ff <= bus.ctl[C_FRAME];
      unique case (t_ff)
        G_IDLE: begin
          if (!bus.ctl[C_FRAME] && frame_q_ff && m_ff == H_IDLE && hbp_is_mem(bus.cbe)) begin
            t_o_ff <= 3'h3;
            t_oe_ff <= '1;
            t_idx_ff <= bus.ad[5:2];
            t_wr_ff <= hbp_is_wr(bus.cbe);
            t_ff <= G_CLAIM;
          end
        end
        G_CLAIM: begin
          t_o_ff <= 3'h2;
          t_ad_ff <= mem[t_idx_ff];
          t_ad_oe_ff <= !t_wr_ff;
          t_ff <= G_DATA;
        end
        G_DATA: begin
          if (!bus.ctl[C_IRDY]) begin
            for (int b = 0; b < CBE_W; b++) begin
              if (t_wr_ff && !bus.cbe[b]) begin
                mem[t_idx_ff][8*b +: 8] <= bus.ad[8*b +: 8];
              end
            end
            t_o_ff <= '1;
            t_ad_oe_ff <= 1'b0;
            t_ff <= G_END;
          end
        end
        G_END: begin
          t_oe_ff <= '0;
          t_ff <= G_IDLE;
        end
      endcase
    end
  end
  // ***************************************************
  // Parity generation, checking and error pin
  // ***************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_o_ff <= 1'b0;
      par_oe_ff <= 1'b0;
      dchk_ff <= 1'b0;
      dpar_ff <= 1'b0;
    end else begin
      par_o_ff <= hbp_par(ad_o, bus.cbe);
      par_oe_ff <= m_ad_oe_ff | t_ad_oe_ff;
      dchk_ff <= (t_ff == G_DATA && !bus.ctl[C_IRDY] && t_wr_ff)
        || (m_ff == H_DATA && !bus.ctl[C_TRDY] && !bus.ctl[C_DEVSEL] && !hbp_is_wr(cmd_ff));
      dpar_ff <= hbp_par(bus.ad, bus.cbe);
    end
  end
  assign perr_det = dchk_ff && (bus.par != dpar_ff);
  // Error low one clock, high one clock, then released
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      perr_o_ff <= 1'b1;
      perr_oe_ff <= 1'b0;
      perr_hold_ff <= 1'b0;
      o_h_perr_evt <= 1'b0;
    end else begin
      o_h_perr_evt <= perr_det;
      if (perr_det) begin
        perr_o_ff <= 1'b0;
        perr_oe_ff <= 1'b1;
        perr_hold_ff <= 1'b0;
      end else if (!perr_o_ff) begin
        perr_o_ff <= 1'b1;
        perr_hold_ff <= 1'b1;
      end else if (perr_hold_ff) begin
        perr_oe_ff <= 1'b0;
        perr_hold_ff <= 1'b0;
      end
    end
  end
endmodule

// >>> hbp_bus_chk.sv
// Protocol checker watching the shared wires of the host bus port
module hbp_bus_chk
  import hbp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic [CTL_W-1:0] ctl,
  input wire logic req_n,
  input wire logic gnt_n,
  input wire logic idsel,
  input wire logic serr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************
  // Wire rules
  // ***************************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic dph;
  // Completion edge needs both readies low at once
  assign dph = !ctl[C_IRDY] && !ctl[C_TRDY];
  AST_ADDR_PAR:
    assert property ($fell(ctl[C_FRAME]) |=> par == ^{$past(ad), $past(cbe)}) else $error("ap");
  AST_DATA_PAR:
    assert property (dph |=> par == ^{$past(ad), $past(cbe)}) else $error("dp");
  AST_FRAME_LAST:
    assert property ($fell(ctl[C_FRAME]) |=> ctl[C_FRAME] && !ctl[C_IRDY]) else $error("fr");
  AST_READY_HIGH:
    assert property (dph |=> ctl[C_IRDY] && ctl[C_TRDY]) else $error("rdy");
  AST_CFG_SEL:
    assert property ($fell(ctl[C_FRAME]) && cbe[3:1] == 3'h5 |=> ctl[C_DEVSEL] == !$past(idsel))
      else $error("cfg");
  AST_GNT_REQ:
    assert property ($fell(gnt_n) |-> !$past(req_n)) else $error("gnt");
  AST_SERR_ONE:
    assert property ($fell(serr_n) |=> serr_n) else $error("serr");
  AST_PERR_TWO:
    assert property ($fell(ctl[C_PERR]) |-> $past(dph, 2)) else $error("perr");
  cover property (dph);
  cover property ($fell(gnt_n));
  cover property ($fell(ctl[C_FRAME]) && cbe[3:1] == 3'h5);
endmodule

// >>> pci_bus_master_target_port_tb.sv
// Bench joining device and host ends of the host bus port
module pci_bus_master_target_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hbp_pkg::*;
  // ***************************************************
  // Stimulus, ends and checker
  // ***************************************************
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic irq = 1'b0, h_req = 1'b0, m_req = 1'b0, m_done, h_done, h_irq, tgt_wr;
  logic [3:0] cmd = 4'h0, be = 4'h0, tgt_be, wr_b;
  logic [31:0] addr = 32'h0, wdata = 32'h0, m_rd, h_rd, tgt_a, tgt_d, wr_a, wr_d;
  hbp_stat_t m_st, h_st;
  logic m_busy, h_busy, tgt_rd, s_ev, p_ev, hp_ev, hs_ev;
  logic [3:0] tgt_c, last_c;
  logic [3:0] err_seen = 4'h0;
  int fails = 0;
  int total_checks = 0;
  hbp_bus_if hbp_bus_if_i ();
  // Read data echoes the inverted address so decode slips show up
  hbp_dev_end hbp_dev_end_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .bus(hbp_bus_if_i),
    .i_irq(irq), .i_mst_req(m_req), .i_mst_cmd(cmd), .i_mst_addr(addr), .i_mst_wdata(wdata),
    .i_mst_be(be), .o_mst_busy(m_busy), .o_mst_done(m_done), .o_mst_rdata(m_rd),
    .o_mst_stat(m_st), .o_tgt_rd(tgt_rd), .o_tgt_wr(tgt_wr), .o_tgt_cmd(tgt_c),
    .o_tgt_addr(tgt_a), .o_tgt_wdata(tgt_d), .o_tgt_be(tgt_be), .i_tgt_rdata(~tgt_a),
    .o_serr_evt(s_ev), .o_perr_evt(p_ev));
  hbp_host_end hbp_host_end_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .bus(hbp_bus_if_i),
    .i_h_req(h_req), .i_h_cmd(cmd), .i_h_addr(addr), .i_h_wdata(wdata), .i_h_be(be),
    .o_h_busy(h_busy), .o_h_done(h_done), .o_h_rdata(h_rd), .o_h_stat(h_st),
    .o_h_perr_evt(hp_ev), .o_h_irq(h_irq), .o_h_serr(hs_ev));
  hbp_bus_chk hbp_bus_chk_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .ad(hbp_bus_if_i.ad),
    .cbe(hbp_bus_if_i.cbe), .par(hbp_bus_if_i.par), .ctl(hbp_bus_if_i.ctl),
    .req_n(hbp_bus_if_i.req_n), .gnt_n(hbp_bus_if_i.gnt_n), .idsel(hbp_bus_if_i.idsel),
    .serr_n(hbp_bus_if_i.serr_n));
  initial forever #20 i_mclk = ~i_mclk;
  // Hold the last target write, its pulse lasts one cycle only
  always @(posedge i_mclk) if (tgt_wr === 1'b1) {wr_a, wr_d, wr_b} <= {tgt_a, tgt_d, tgt_be};
  always @(posedge i_mclk) if (tgt_wr === 1'b1 || tgt_rd === 1'b1) last_c <= tgt_c;
  // No lane is ever corrupted here, so any error report is a false alarm
  always @(posedge i_mclk) if (i_resetn) err_seen <= err_seen | {s_ev, p_ev, hp_ev, hs_ev};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access from the device master (dv=1) or the host initiator
  task automatic op(input bit dv, input logic [3:0] c, input logic [31:0] a, w,
    input logic [3:0] b, input logic [31:0] exp, input hbp_stat_t es);
    int n;
    n = 0;
    repeat (3) @(posedge i_mclk);
    {cmd, addr, wdata, be} <= {c, a, w, b};
    m_req <= dv;
    h_req <= !dv;
    @(posedge i_mclk);
    m_req <= 1'b0;
    h_req <= 1'b0;
    do begin
      @(negedge i_mclk);
      n++;
    end while ((dv ? m_done : h_done) !== 1'b1 && n < 300);
    @(negedge i_mclk);
    chk({31'h0, n < 300}, 32'h1);
    chk({30'h0, dv ? m_st : h_st}, {30'h0, es});
    if (!c[0] && es == ST_OK) chk(dv ? m_rd : h_rd, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    fails++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    op(0, CMD_MEM_WR, DEV_MEM_BASE + 32'h8, 32'hCAFE_0123, 4'h5, 32'h0, ST_OK);
    chk(wr_a, DEV_MEM_BASE + 32'h8);
    chk(wr_d, 32'hCAFE_0123);
    chk({28'h0, wr_b}, 32'h5);
    op(0, CMD_MEM_RD, DEV_MEM_BASE + 32'h6, 0, 4'h0, ~(DEV_MEM_BASE + 32'h4), ST_OK);
    op(0, CMD_IO_RD, DEV_IO_BASE + 32'h3, 0, 4'h0, ~(DEV_IO_BASE + 32'h3), ST_OK);
    op(0, CMD_IO_WR, DEV_IO_BASE + 32'h1, 32'h0000_A500, 4'hD, 0, ST_OK);
    chk(wr_a, DEV_IO_BASE + 32'h1);
    chk(wr_d, 32'h0000_A500);
    chk({28'h0, last_c}, {28'h0, CMD_IO_WR});
    op(0, CMD_CFG_RD, 32'h8, 0, 4'h0, ~32'h8, ST_OK);
    chk({28'h0, last_c}, {28'h0, CMD_CFG_RD});
    op(0, CMD_CFG_WR, 32'h3C, 32'h0000_0055, 4'hE, 0, ST_OK);
    chk(wr_a, 32'h3C);
    op(0, CMD_MEM_RD, 32'h4000_0000, 0, 4'h0, 0, ST_ABORT);
    op(0, CMD_SPECIAL, 32'h0, 0, 4'h0, 0, ST_ABORT);
    op(1, CMD_MEM_WR, 32'h10, 32'hFFFF_FFFF, 4'h0, 0, ST_OK);
    op(1, CMD_MEM_WR, 32'h10, 32'h1234_5678, 4'hC, 0, ST_OK);
    op(1, CMD_MEM_RD, 32'h10, 0, 4'h0, 32'hFFFF_5678, ST_OK);
    op(1, CMD_IO_RD, 32'h10, 0, 4'h0, 0, ST_ABORT);
    @(posedge i_mclk);
    irq <= 1'b1;
    repeat (3) @(negedge i_mclk);
    chk({31'h0, h_irq}, 32'h1);
    @(posedge i_mclk);
    irq <= 1'b0;
    repeat (3) @(negedge i_mclk);
    chk({31'h0, h_irq}, 32'h0);
    chk({28'h0, err_seen}, 32'h0);
    chk({30'h0, m_busy, h_busy}, 32'h0);
    conclude();
  end
endmodule
